// [rtl/fts_pkg.sv]
// constants, field layouts and types of the fault timer supervisor
// assumes one 200 MHz clock and measurements already scaled to 0.1 % units
package fts_pkg;
  localparam int NCH = 8;
  localparam int NHIST = 4;
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  // levels in 0.1 % units of the current limit or of the speed span
  localparam logic [16:0] LIMIT_LVL = 17'h003E8;
  localparam logic [15:0] OVERLAP_LVL = 16'h0064;
  localparam logic [15:0] CMD_COIL_LVL = 16'h00FA;
  localparam logic [15:0] GAIN_DIV = 16'h0064;
  localparam logic [31:0] INTEG_DIV = 32'h000003E8;
  localparam logic [23:0] INTEG_MAX = 24'hFFFFFF;
  localparam logic [15:0] TIME_MAX = 16'hFFFF;
  // channels and fault codes (code is channel plus one)
  localparam int CH_COC = 0;
  localparam int CH_BOC = 1;
  localparam int CH_OVL = 2;
  localparam int CH_CCOIL = 3;
  localparam int CH_BCOIL = 4;
  localparam int CH_OSPD = 5;
  localparam int CH_USPD = 6;
  localparam int CH_FBL = 7;
  localparam logic [3:0] CODE_NONE = 4'h0;
  // reset values
  localparam logic [15:0] PCT_RST [NCH] = '{16'h012C, 16'h012C, 16'h0064,
    16'h0001, 16'h0001, 16'h012C, 16'h012C, 16'h012C};
  localparam logic [15:0] TIME_RST [NCH] = '{16'h09C4, 16'h09C4, 16'h09C4,
    16'h09C4, 16'h09C4, 16'h07D0, 16'h07D0, 16'h07D0};
  localparam logic [15:0] KP_RST = 16'h0014;
  localparam logic [15:0] KI_RST = 16'h0050;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FAULT = 8'h04;
  localparam logic [7:0] OFF_PRIOR = 8'h08;
  localparam logic [7:0] OFF_IRQ_STS = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h1C;
  localparam logic [7:0] OFF_PCT = 8'h20;
  localparam logic [7:0] OFF_TIME = 8'h24;
  localparam logic [7:0] CH_STRIDE = 8'h08;
  localparam logic [7:0] OFF_KP = 8'h60;
  localparam logic [7:0] OFF_KI = 8'h64;
  localparam logic [7:0] OFF_COND = 8'h68;
  // fields
  localparam int CTRL_CLR_EN = 0;
  localparam int CTRL_CLR_GO = 1;
  localparam int IRQ_TRIP = 0;
  localparam int IRQ_CLEAR = 1;
  localparam int IRQ_ERASE = 2;
  localparam int NIRQ = 3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic [15:0] clutch;
    logic [15:0] brake;
    logic [15:0] cmd;
    logic [15:0] speed;
    logic [15:0] setpoint;
    logic fb_ok;
  } fts_meas_type;

  typedef struct packed {
    logic sel;
    logic [1:0] trans;
    logic write;
    logic [2:0] size;
    logic [7:0] addr;
  } fts_ahb_req_type;
endpackage : fts_pkg

// [rtl/fts_supervisor.sv]
// fault timer supervisor: condition checks, millisecond persistence timers,
// fault history, clear handling, overload phase-back, AHB-Lite registers
// assumes synchronous measurement inputs and a single AHB-Lite master
`timescale 1ns/10ps
module fts_supervisor #(
  parameter int TICK_CYCLES = fts_pkg::MS_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire fts_pkg::fts_meas_type meas,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [3:0] fault_code,
  output logic fault_active,
  output logic [15:0] phase_back,
  output logic irq
);
  import fts_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES + 1);

  logic [TW-1:0] tick_cnt;
  logic tick;
  logic [15:0] pct [NCH];
  logic [15:0] tim [NCH];
  logic [15:0] cnt [NCH];
  logic [NCH-1:0] cond, next_cond, tripped, trip;
  logic [3:0] new_code, last_code;
  logic [3:0] prior [NHIST];
  logic new_fault;
  logic clear_en, clear_go;
  logic [NIRQ-1:0] irq_sts, irq_mask, irq_set;
  logic [15:0] kp, ki;
  logic [15:0] excess;
  logic [23:0] integ;
  logic [31:0] rd_val;
  fts_ahb_req_type ap;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic wr_en;

  //////////////////////////////////////////////////////////////////////////
  // millisecond timebase
  always_ff @(posedge mclk) begin
    if (rst || tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end
  assign tick = (tick_cnt == TW'(TICK_CYCLES - 1));

  //////////////////////////////////////////////////////////////////////////
  // abnormal conditions, registered once so the timers see clean levels
  always_comb begin
    next_cond = '0;
    next_cond[CH_COC] = {1'b0, meas.clutch} > LIMIT_LVL + pct[CH_COC];
    next_cond[CH_BOC] = {1'b0, meas.brake} > LIMIT_LVL + pct[CH_BOC];
    next_cond[CH_OVL] = (meas.clutch > OVERLAP_LVL) &&
      (meas.brake > OVERLAP_LVL);
    next_cond[CH_CCOIL] = (meas.cmd >= CMD_COIL_LVL) &&
      (meas.clutch < pct[CH_CCOIL]);
    next_cond[CH_BCOIL] = (meas.cmd >= CMD_COIL_LVL) &&
      (meas.brake < pct[CH_BCOIL]);
    next_cond[CH_OSPD] = {1'b0, meas.speed} >
      {1'b0, meas.setpoint} + {1'b0, pct[CH_OSPD]};
    next_cond[CH_USPD] = {1'b0, meas.speed} + {1'b0, pct[CH_USPD]} <
      {1'b0, meas.setpoint};
    next_cond[CH_FBL] = !meas.fb_ok && (meas.clutch >= pct[CH_FBL]);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cond <= '0;
    end else begin
      cond <= next_cond;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // persistence timers, one per channel
  // a time of zero trips on the first cycle the condition is seen
  generate
    for (genvar g = 0; g < NCH; g++) begin : g_timer
      always_ff @(posedge mclk) begin
        if (rst || !cond[g]) begin
          cnt[g] <= '0;
          tripped[g] <= 1'b0;
        end else begin
          if (tick && cnt[g] != TIME_MAX) begin
            cnt[g] <= cnt[g] + 1'b1;
          end
          if (cnt[g] >= tim[g]) begin
            tripped[g] <= 1'b1;
          end
        end
      end
      assign trip[g] = cond[g] && (cnt[g] >= tim[g]) && !tripped[g];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // fault capture and history; lowest channel wins a same-cycle tie
  always_comb begin
    new_code = CODE_NONE;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (trip[i]) begin
        new_code = 4'(i + 1);
      end
    end
  end
  assign new_fault = (new_code != CODE_NONE);

  always_ff @(posedge mclk) begin
    if (rst) begin
      fault_code <= CODE_NONE;
      last_code <= CODE_NONE;
      for (int k = 0; k < NHIST; k++) begin
        prior[k] <= CODE_NONE;
      end
    end else if (new_fault) begin
      // a new trip beats a clear landing in the same cycle
      fault_code <= new_code;
      last_code <= new_code;
      if (last_code != CODE_NONE) begin
        prior[0] <= last_code;
        for (int k = 1; k < NHIST; k++) begin
          prior[k] <= prior[k-1];
        end
      end
    end else if (clear_go) begin
      if (fault_code != CODE_NONE) begin
        fault_code <= CODE_NONE;
      end else begin
        last_code <= CODE_NONE;
        for (int k = 0; k < NHIST; k++) begin
          prior[k] <= CODE_NONE;
        end
      end
    end
  end
  assign fault_active = (fault_code != CODE_NONE);

  //////////////////////////////////////////////////////////////////////////
  // overload phase-back: proportional plus integral on the worst excess
  always_comb begin
    excess = '0;
    if ({1'b0, meas.clutch} > LIMIT_LVL) begin
      excess = meas.clutch - LIMIT_LVL[15:0];
    end
    if ({1'b0, meas.brake} > LIMIT_LVL &&
        meas.brake - LIMIT_LVL[15:0] > excess) begin
      excess = meas.brake - LIMIT_LVL[15:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || excess == '0) begin
      integ <= '0;
    end else if (tick) begin
      // saturate rather than wrap; a wrap would drop the phase-back
      if ({8'h00, integ} + (kp_dummy(ki, excess)) > {8'h00, INTEG_MAX}) begin
        integ <= INTEG_MAX;
      end else begin
        integ <= 24'(integ + kp_dummy(ki, excess));
      end
    end
  end

  // scaled gain product: gain in percent, extra divide for the integrator
  function automatic logic [31:0] kp_dummy(input logic [15:0] gain,
                                           input logic [15:0] err);
    logic [31:0] prod;
    prod = gain * err;
    kp_dummy = prod / (32'(GAIN_DIV) * INTEG_DIV);
  endfunction : kp_dummy

  always_ff @(posedge mclk) begin
    logic [31:0] sum;
    sum = (kp * excess) / 32'(GAIN_DIV) + {8'h00, integ};
    if (rst) begin
      phase_back <= '0;
    end else if (sum > {16'h0000, TIME_MAX}) begin
      phase_back <= TIME_MAX;
    end else begin
      phase_back <= sum[15:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY
  // read data is taken in the address phase, so a read right after a
  // write to the same register returns the old value
  assign ap = '{sel: hsel, trans: htrans, write: hwrite, size: hsize,
                addr: haddr[7:0]};
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_en = wr_pend;

  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else if (hready) begin
      wr_pend <= ap.sel && ap.trans == HTRANS_NONSEQ && ap.write;
      wr_addr <= ap.addr;
    end
  end

  always_comb begin
    rd_val = '0;
    unique case (ap.addr)
      OFF_CTRL: rd_val[CTRL_CLR_EN] = clear_en;
      OFF_FAULT: rd_val[3:0] = fault_code;
      OFF_IRQ_STS: rd_val[NIRQ-1:0] = irq_sts;
      OFF_IRQ_MASK: rd_val[NIRQ-1:0] = irq_mask;
      OFF_KP: rd_val[15:0] = kp;
      OFF_KI: rd_val[15:0] = ki;
      OFF_COND: rd_val[NCH-1:0] = cond;
      default: rd_val = '0;
    endcase
    for (int k = 0; k < NHIST; k++) begin
      if (ap.addr == 8'(OFF_PRIOR + 8'(4 * k))) begin
        rd_val[3:0] = prior[k];
      end
    end
    for (int i = 0; i < NCH; i++) begin
      if (ap.addr == 8'(OFF_PCT + 8'(i) * CH_STRIDE)) begin
        rd_val[15:0] = pct[i];
      end
      if (ap.addr == 8'(OFF_TIME + 8'(i) * CH_STRIDE)) begin
        rd_val[15:0] = tim[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      hrdata <= '0;
    end else if (hready && ap.sel && ap.trans == HTRANS_NONSEQ &&
                 !ap.write) begin
      hrdata <= rd_val;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // software-written settings
  always_ff @(posedge mclk) begin
    if (rst) begin
      clear_en <= 1'b0;
      irq_mask <= '0;
      kp <= KP_RST;
      ki <= KI_RST;
      for (int i = 0; i < NCH; i++) begin
        pct[i] <= PCT_RST[i];
        tim[i] <= TIME_RST[i];
      end
    end else if (wr_en) begin
      if (wr_addr == OFF_CTRL) clear_en <= hwdata[CTRL_CLR_EN];
      if (wr_addr == OFF_IRQ_MASK) irq_mask <= hwdata[NIRQ-1:0];
      if (wr_addr == OFF_KP) kp <= hwdata[15:0];
      if (wr_addr == OFF_KI) ki <= hwdata[15:0];
      for (int i = 0; i < NCH; i++) begin
        if (wr_addr == 8'(OFF_PCT + 8'(i) * CH_STRIDE)) pct[i] <= hwdata[15:0];
        if (wr_addr == 8'(OFF_TIME + 8'(i) * CH_STRIDE)) tim[i] <= hwdata[15:0];
      end
    end
  end

  // clear acts only when enabled before the command write
  assign clear_go = wr_en && wr_addr == OFF_CTRL && hwdata[CTRL_CLR_GO] &&
    clear_en;

  //////////////////////////////////////////////////////////////////////////
  // interrupts: sticky, write one to clear, set wins
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_TRIP] = new_fault;
    irq_set[IRQ_CLEAR] = clear_go && fault_active && !new_fault;
    irq_set[IRQ_ERASE] = clear_go && !fault_active && !new_fault;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_sts <= '0;
    end else if (wr_en && wr_addr == OFF_IRQ_STS) begin
      irq_sts <= (irq_sts & ~hwdata[NIRQ-1:0]) | irq_set;
    end else begin
      irq_sts <= irq_sts | irq_set;
    end
  end
  assign irq = |(irq_sts & irq_mask);

  //////////////////////////////////////////////////////////////////////////
  // checks
  property p_coc_trip_time;
    @(posedge mclk) disable iff (rst)
      trip[CH_COC] |-> cond[CH_COC] && cnt[CH_COC] >= tim[CH_COC];
  endproperty
  a_coc_trip_time: assert property (p_coc_trip_time)
    else $error("clutch overcurrent tripped before its time");

  property p_boc_flag;
    @(posedge mclk) disable iff (rst)
      ({1'b0, meas.brake} > LIMIT_LVL + pct[CH_BOC]) |=> cond[CH_BOC];
  endproperty
  a_boc_flag: assert property (p_boc_flag)
    else $error("brake overcurrent not flagged");

  property p_ovl_flag;
    @(posedge mclk) disable iff (rst)
      cond[CH_OVL] |-> $past(meas.clutch) > OVERLAP_LVL &&
        $past(meas.brake) > OVERLAP_LVL;
  endproperty
  a_ovl_flag: assert property (p_ovl_flag)
    else $error("overlap flagged without both currents");

  property p_restart;
    @(posedge mclk) disable iff (rst)
      !cond[CH_OSPD] |=> cnt[CH_OSPD] == '0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("overspeed timer did not restart");

  property p_trip_to_fault;
    @(posedge mclk) disable iff (rst)
      trip[CH_FBL] && trip[CH_COC] == 1'b0 && new_code == 4'(CH_FBL + 1)
        |=> fault_code == 4'(CH_FBL + 1) ##0 irq_sts[IRQ_TRIP];
  endproperty
  a_trip_to_fault: assert property (p_trip_to_fault)
    else $error("feedback loss trip not recorded");

  property p_history;
    @(posedge mclk) disable iff (rst)
      new_fault && last_code != CODE_NONE |=>
        prior[0] == $past(last_code) && prior[1] == $past(prior[0]);
  endproperty
  a_history: assert property (p_history)
    else $error("fault history did not shift");

  property p_clear_active;
    @(posedge mclk) disable iff (rst)
      clear_go && fault_active && !new_fault |=>
        !fault_active && prior[0] == $past(prior[0]);
  endproperty
  a_clear_active: assert property (p_clear_active)
    else $error("active fault not cleared");

  property p_erase;
    @(posedge mclk) disable iff (rst)
      clear_go && !fault_active && !new_fault |=>
        prior[0] == CODE_NONE && prior[NHIST-1] == CODE_NONE;
  endproperty
  a_erase: assert property (p_erase)
    else $error("history not erased");

  property p_clear_disabled;
    @(posedge mclk) disable iff (rst)
      !clear_en && !new_fault |=> fault_code == $past(fault_code);
  endproperty
  a_clear_disabled: assert property (p_clear_disabled)
    else $error("fault changed while clearing disabled");

  property p_phase_idle;
    @(posedge mclk) disable iff (rst)
      (excess == '0) [*2] |=> phase_back == '0;
  endproperty
  a_phase_idle: assert property (p_phase_idle)
    else $error("phase-back without excess current");

  property p_integ_grow;
    @(posedge mclk) disable iff (rst)
      tick && excess != '0 && $past(excess) != '0 && integ != INTEG_MAX
        |=> integ >= $past(integ);
  endproperty
  a_integ_grow: assert property (p_integ_grow)
    else $error("integral term shrank under excess");

  c_trip: cover property (@(posedge mclk) disable iff (rst) new_fault);
  c_clear: cover property (@(posedge mclk) disable iff (rst)
    clear_go && fault_active);
  c_erase: cover property (@(posedge mclk) disable iff (rst)
    clear_go && !fault_active);
  c_phase: cover property (@(posedge mclk) disable iff (rst)
    phase_back != '0);
endmodule : fts_supervisor

// [bench/fts_stage.sv]
// partner model: clutch/brake power stage with coil current and tach lag
// assumes the bench sets the wanted measurements on demand each cycle
`timescale 1ns/10ps
module fts_stage
  import fts_pkg::*;
#(
  parameter int LAG = 2
) (
  input wire logic mclk,
  input wire fts_pkg::fts_meas_type demand,
  input wire logic slow,
  output fts_pkg::fts_meas_type meas
);
  fts_meas_type pipe [LAG];

  ////////////////////////////////////////////////////////////////////////
  // every measurement settles one cycle late; slow mode makes it the full LAG cycles late
  always_ff @(posedge mclk) begin
    pipe[0] <= demand;
    for (int i = 1; i < LAG; i++) begin
      pipe[i] <= pipe[i - 1];
    end
  end

  assign meas = slow ? pipe[LAG - 1] : pipe[0];
endmodule : fts_stage

// [bench/testbench.sv]
// self-checking bench for the fault timer supervisor
// assumes the stage model on meas and a zero-wait AHB-Lite slave
`timescale 1ns/10ps
module testbench;
  import fts_pkg::*;
  localparam int TICK = 4;
  localparam int TM = 3;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic slow = 1'b0;
  fts_meas_type dem;
  fts_meas_type meas;
  logic hready, hresp, fault_active, irq;
  logic [31:0] hrdata, rd;
  logic [3:0] fault_code, last;
  logic [15:0] phase_back;
  logic [3:0] prior [NHIST];
  int error_cnt = 0;
  int total_checks = 0;
  int seed = 15280;
  int e, n;

  always #2.5 mclk = ~mclk;

  fts_stage #(.LAG(2)) stage (.mclk(mclk), .demand(dem), .slow(slow),
    .meas(meas));
  fts_supervisor #(.TICK_CYCLES(TICK)) DUT (.mclk(mclk), .rst(rst),
    .meas(meas), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .fault_code(fault_code), .fault_active(fault_active),
    .phase_back(phase_back), .irq(irq));

  ////////////////////////////////////////////////////////////////////////
  function automatic fts_meas_type idle_meas();
    fts_meas_type m;
    m.clutch = 16'h01F4;
    m.brake = 16'h0000;
    m.cmd = 16'h0000;
    m.speed = 16'h1388;
    m.setpoint = 16'h1388;
    m.fb_ok = 1'b1;
    return m;
  endfunction : idle_meas

  // exactly one abnormal condition per channel
  function automatic fts_meas_type fault_meas(input int ch);
    fts_meas_type m;
    m = idle_meas();
    case (ch)
      0: m.clutch = 16'h0578;
      1: begin
        m.clutch = 16'h0000;
        m.brake = 16'h0578;
      end
      2: m.brake = 16'h01F4;
      3: begin
        m.cmd = 16'h012C;
        m.clutch = 16'h0000;
        m.brake = 16'h01F4;
      end
      4: m.cmd = 16'h012C;
      5: m.speed = 16'h1518;
      6: m.speed = 16'h11F8;
      default: m.fb_ok = 1'b0;
    endcase
    return m;
  endfunction : fault_meas

  function automatic logic [7:0] pa(input int i);
    return OFF_PCT + 8'(i) * CH_STRIDE;
  endfunction : pa

  task automatic chk(input string nm, input logic [31:0] ex,
    input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic wait_rdy();
    // no cycle count assumed; only the watchdog ends a hung wait
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
  endtask : wait_rdy

  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    if (!mclk) @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus

  task automatic rdchk(input string nm, input logic [7:0] a,
    input logic [31:0] ex);
    bus(1'b0, a, 32'h0);
    chk(nm, ex, rd);
  endtask : rdchk

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    finish_test();
  end

  initial begin
    dem = idle_meas();
    last = 4'h0;
    for (int k = 0; k < NHIST; k++) prior[k] = 4'h0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk("reset out", 32'h0, {fault_active, irq, hresp, phase_back});
    for (int i = 0; i < NCH; i++) begin
      rdchk("pct", pa(i), {16'h0, PCT_RST[i]});
      rdchk("time", pa(i) + 8'h04, {16'h0, TIME_RST[i]});
      bus(1'b1, pa(i) + 8'h04, TM);
    end
    rdchk("kp", OFF_KP, {16'h0, KP_RST});
    rdchk("ki", OFF_KI, {16'h0, KI_RST});
    rdchk("ctrl", OFF_CTRL, 32'h0);
    bus(1'b1, 8'h7C, 32'hFFFF);
    rdchk("unmapped", 8'h7C, 32'h0);
    // integrator off so the proportional part shows alone
    bus(1'b1, OFF_KI, 32'h0);
    for (int i = 0; i < 6; i++) begin
      e = (i == 0) ? 1 : (i == 1) ? 300 : 1 + {$random(seed)} % 300;
      dem.clutch <= LIMIT_LVL[15:0] + 16'(e);
      repeat (6) @(posedge mclk);
      chk("pb prop", 32'(KP_RST) * e / 100, phase_back);
      dem <= idle_meas();
      repeat (4) @(posedge mclk);
    end
    // 1000 percent on 300 excess gives exactly 3 per tick
    bus(1'b1, OFF_KI, 32'h3E8);
    dem.clutch <= LIMIT_LVL[15:0] + 16'h012C;
    repeat (42) @(posedge mclk);
    chk("pb step", 32'h0, (phase_back - 16'h003C) % 3);
    chk("pb span", 32'h1, phase_back >= 84 && phase_back <= 93);
    dem <= idle_meas();
    repeat (6) @(posedge mclk);
    chk("pb release", 32'h0, phase_back);
    for (int ch = 0; ch < NCH; ch++) begin
      slow <= ch[0];
      repeat (4) @(posedge mclk);
      dem <= fault_meas(ch);
      repeat (4) @(posedge mclk);
      dem <= idle_meas();
      repeat (3) @(posedge mclk);
      dem <= fault_meas(ch);
      for (n = 0; n < 40 && fault_code === 4'h0; n++) @(negedge mclk);
      chk("trip early", 32'h1, n >= 8);
      chk("trip late", 32'h1, n <= 24);
      chk("code", ch + 1, fault_code);
      if (last !== 4'h0) begin
        for (int k = NHIST - 1; k > 0; k--) prior[k] = prior[k - 1];
        prior[0] = last;
      end
      last = 4'(ch + 1);
      rdchk("cond", OFF_COND, 32'h1 << ch);
      bus(1'b1, OFF_FAULT, 32'hF);
      bus(1'b1, OFF_PRIOR, 32'hF);
      rdchk("fault reg", OFF_FAULT, {28'h0, last});
      for (int k = 0; k < NHIST; k++) begin
        rdchk("prior", OFF_PRIOR + 8'(4 * k), {28'h0, prior[k]});
      end
      if (ch == 0) begin
        chk("irq masked", 32'h0, irq);
        rdchk("sts trip", OFF_IRQ_STS, 32'h1);
        bus(1'b1, OFF_IRQ_MASK, 32'h7);
        @(negedge mclk);
        chk("irq on", 32'h1, irq);
        bus(1'b1, OFF_IRQ_STS, 32'h1);
        @(negedge mclk);
        chk("irq off", 32'h0, irq);
        bus(1'b1, OFF_CTRL, 32'h3);
        @(negedge mclk);
        chk("clear off", 32'h1, fault_code);
      end
      if (!mclk) @(posedge mclk);
      dem <= idle_meas();
      bus(1'b1, OFF_CTRL, 32'h3);
      @(negedge mclk);
      chk("cleared", 32'h0, fault_code);
      rdchk("kept", OFF_PRIOR, {28'h0, prior[0]});
    end
    bus(1'b1, OFF_CTRL, 32'h3);
    for (int k = 0; k < NHIST; k++) begin
      rdchk("erased", OFF_PRIOR + 8'(4 * k), 32'h0);
    end
    rdchk("sts all", OFF_IRQ_STS, 32'h7);
    bus(1'b1, OFF_IRQ_STS, 32'h7);
    @(negedge mclk);
    chk("irq end", 32'h0, irq);
    finish_test();
  end
endmodule : testbench
